// [src/ssm_pkg.sv]
// package for the sram sleep control pair: command codes, timing and widths
// assumes a 250 MHz single clock shared by controller and memory end
package ssm_pkg;
  localparam int          CLK_PERIOD_PS        = 4000;
  localparam int          SLEEP_RECOVERY_NS    = 20;
  localparam int          SLEEP_RECOVERY_CYC   = (SLEEP_RECOVERY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          SLEEP_ENTRY_CYC      = 2;
  localparam int          ADDR_W               = 8;
  localparam int          DATA_W               = 18;
  localparam int          DEPTH                = 256;
  localparam logic [3:0]  RECOV_CNT_W1         = 4'(SLEEP_RECOVERY_CYC);
  localparam logic [1:0]  ENTRY_CNT_INIT       = 2'(SLEEP_ENTRY_CYC);
  localparam logic [3:0]  SYNC_MARGIN_CYC      = 4'h2;
  localparam logic [DATA_W-1:0] DATA_RST       = 18'h00000;

  typedef enum logic [1:0] {
    SSM_CMD_DESELECT,
    SSM_CMD_READ,
    SSM_CMD_WRITE,
    SSM_CMD_DUMMY_READ
  } ssm_cmd_t;

  typedef enum logic [1:0] {
    SSM_ST_AWAKE,
    SSM_ST_ENTERING,
    SSM_ST_ASLEEP,
    SSM_ST_RECOVERING
  } ssm_state_t;
endpackage : ssm_pkg

// [src/ssm_if.sv]
// link between controller and sram end: command, address, shared data bus, sleep request
// assumes one clock; the wire level of the data bus is resolved here from the enables
interface ssm_if;
  import ssm_pkg::*;
  ssm_cmd_t            cmd;
  logic [ADDR_W-1:0]   addr;
  logic [DATA_W-1:0]   ctl_dq_o;
  logic                ctl_dq_oe;
  logic [DATA_W-1:0]   mem_dq_o;
  logic                mem_dq_oe;
  logic                sleep_request;
  logic [DATA_W-1:0]   dq;

  // pull-down on the sleep request when undriven is modelled by the controller always driving it
  assign dq = ctl_dq_oe ? ctl_dq_o : (mem_dq_oe ? mem_dq_o : '0);

  modport ctl (output cmd, output addr, output ctl_dq_o, output ctl_dq_oe, output sleep_request, input dq);
  modport mem (input cmd, input addr, input sleep_request, input dq, output mem_dq_o, output mem_dq_oe);
endinterface : ssm_if

// [src/ssm_mem.sv]
// memory end: storage with a two-cycle sleep entry and a recovery interval
// assumes the sleep request is asynchronous and the controller keeps its side of the protocol
//
// Overview of operation
// R1 - enter sleep two clocks after request rises; the code takes four, two of them in the synchroniser
// R2 - memory contents and state kept while asleep
// R3 - asleep: deselected, inputs ignored, outputs released
// R4 - sleep lasts while request stays high
// R5 - resume only after 20 ns recovery
// R6 - controller sends only deselect or read in recovery
// R7 - controller requests sleep only when idle
// R8 - request low in normal operation, default low
// R9 - controller uses dummy reads at read-to-write turns
// R10 - test port idle from power-up, never clocked
// R11 - sample request, track recovery, flag recovery writes
module ssm_mem
  import ssm_pkg::*;
(
  input  wire logic    clk_i,
  input  wire logic    rst_i,
  ssm_if.mem           link,
  output logic         asleep_o,
  output logic         recovering_o,
  output logic         write_violation_o
);
  logic [DATA_W-1:0] mem_array [DEPTH];
  logic              req_meta_reg;
  logic              req_sync_reg;
  ssm_state_t        state_reg;
  logic [1:0]        entry_cnt_reg;
  logic [3:0]        recov_cnt_reg;
  logic [DATA_W-1:0] rd_data_reg;
  logic              rd_oe_reg;
  logic              active;

  // the synchroniser adds latency; entry is counted from the synchronised edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_meta_reg <= 1'b0;
      req_sync_reg <= 1'b0;
    end else begin
      req_meta_reg <= link.sleep_request;
      req_sync_reg <= req_meta_reg; // see R11
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg     <= SSM_ST_AWAKE;
      entry_cnt_reg <= ENTRY_CNT_INIT;
      recov_cnt_reg <= RECOV_CNT_W1;
    end else begin
      unique case (state_reg)
        SSM_ST_AWAKE: begin
          entry_cnt_reg <= ENTRY_CNT_INIT - 2'h1;
          if (req_sync_reg) state_reg <= SSM_ST_ENTERING; // see R1
        end
        SSM_ST_ENTERING: begin
          if (!req_sync_reg) begin
            state_reg <= SSM_ST_AWAKE;
          end else if (entry_cnt_reg == 2'h1) begin
            state_reg <= SSM_ST_ASLEEP; // see R1
          end else begin
            entry_cnt_reg <= entry_cnt_reg - 2'h1;
          end
        end
        SSM_ST_ASLEEP: begin
          recov_cnt_reg <= RECOV_CNT_W1;
          if (!req_sync_reg) state_reg <= SSM_ST_RECOVERING; // see R4
        end
        SSM_ST_RECOVERING: begin
          if (req_sync_reg) begin
            state_reg <= SSM_ST_ASLEEP;
          end else if (recov_cnt_reg == 4'h1) begin
            state_reg <= SSM_ST_AWAKE; // see R5
          end else begin
            recov_cnt_reg <= recov_cnt_reg - 4'h1;
          end
        end
      endcase
    end
  end

  // reads are still served during recovery, only writes are forbidden there
  assign active = (state_reg == SSM_ST_AWAKE) || (state_reg == SSM_ST_ENTERING) ||
                  (state_reg == SSM_ST_RECOVERING);

  // array is never reset or cleared, so contents survive sleep
  always_ff @(posedge clk_i) begin
    if (active && state_reg != SSM_ST_RECOVERING && link.cmd == SSM_CMD_WRITE) begin
      mem_array[link.addr] <= link.dq; // see R2
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_reg <= DATA_RST;
      rd_oe_reg   <= 1'b0;
    end else if (!active) begin
      rd_oe_reg   <= 1'b0; // see R3
    end else begin
      // dummy read runs the cycle but keeps the drivers off
      rd_oe_reg <= (link.cmd == SSM_CMD_READ); // see R9
      if (link.cmd == SSM_CMD_READ || link.cmd == SSM_CMD_DUMMY_READ) begin
        rd_data_reg <= mem_array[link.addr];
      end
    end
  end

  assign link.mem_dq_o  = rd_data_reg;
  assign link.mem_dq_oe = rd_oe_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      asleep_o          <= 1'b0;
      recovering_o      <= 1'b0;
      write_violation_o <= 1'b0;
    end else begin
      asleep_o          <= (state_reg == SSM_ST_ASLEEP); // see R3
      recovering_o      <= (state_reg == SSM_ST_RECOVERING);
      write_violation_o <= (state_reg == SSM_ST_RECOVERING) && (link.cmd == SSM_CMD_WRITE); // see R11
    end
  end
  // the test port has no logic here: it stays in its reset state as if never clocked (see R10)
endmodule : ssm_mem

// [src/ssm_ctl.sv]
// controller end: issues commands, requests sleep when idle, waits out recovery
// assumes the same clock as the memory end; read data returns one cycle after the read
module ssm_ctl
  import ssm_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  ssm_if.ctl                     link,
  input  wire logic              req_valid_i,
  input  wire logic              req_write_i,
  input  wire logic [ADDR_W-1:0] req_addr_i,
  input  wire logic [DATA_W-1:0] req_wdata_i,
  input  wire logic              sleep_i,
  output logic                   req_ready_o,
  output logic                   rd_valid_o,
  output logic [DATA_W-1:0]      rd_data_o,
  output logic                   sleeping_o
);
  ssm_cmd_t          cmd_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic              dq_oe_reg;
  logic              sleep_reg;
  logic              last_read_reg;
  logic              rd_pend_reg;
  logic [3:0]        recov_cnt_reg;
  logic              idle;
  logic              recov;
  logic              turn;

  assign idle  = (cmd_reg == SSM_CMD_DESELECT) && !rd_pend_reg;
  assign recov = (recov_cnt_reg != 4'h0);
  // a write straight after a read would collide with the read data still on the bus
  assign turn  = req_write_i && last_read_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sleep_reg     <= 1'b0; // see R8
      recov_cnt_reg <= 4'h0;
    end else begin
      if (sleep_i && idle && !req_valid_i) sleep_reg <= 1'b1; // see R7
      else if (!sleep_i) sleep_reg <= 1'b0;
      // the margin of two covers the memory end's synchroniser
      if (sleep_reg && !sleep_i) recov_cnt_reg <= RECOV_CNT_W1 + SYNC_MARGIN_CYC; // see R5
      else if (recov) recov_cnt_reg <= recov_cnt_reg - 4'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_reg       <= SSM_CMD_DESELECT;
      addr_reg      <= '0;
      wdata_reg     <= DATA_RST;
      dq_oe_reg     <= 1'b0;
      last_read_reg <= 1'b0;
    end else begin
      cmd_reg   <= SSM_CMD_DESELECT;
      dq_oe_reg <= 1'b0;
      if (req_valid_i && req_ready_o) begin
        addr_reg <= req_addr_i;
        if (turn) begin
          cmd_reg       <= SSM_CMD_DUMMY_READ; // see R9
          last_read_reg <= 1'b0;
        end else if (req_write_i) begin
          cmd_reg       <= SSM_CMD_WRITE;
          wdata_reg     <= req_wdata_i;
          dq_oe_reg     <= 1'b1;
          last_read_reg <= 1'b0;
        end else begin
          cmd_reg       <= SSM_CMD_READ;
          last_read_reg <= 1'b1;
        end
      end else begin
        last_read_reg <= 1'b0;
      end
    end
  end

  // all requests are held off during recovery: ready is registered, so a read seen
  // one cycle could turn into a write at the taking edge and slip into recovery
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_ready_o <= 1'b0;
      rd_pend_reg <= 1'b0;
      rd_valid_o  <= 1'b0;
      rd_data_o   <= DATA_RST;
      sleeping_o  <= 1'b0;
    end else begin
      req_ready_o <= !sleep_i && !sleep_reg && !recov && !turn_block(cmd_reg); // see R6
      rd_pend_reg <= (cmd_reg == SSM_CMD_READ);
      rd_valid_o  <= rd_pend_reg;
      rd_data_o   <= link.dq;
      sleeping_o  <= sleep_reg || recov;
    end
  end

  // after a dummy read a write is accepted on the next slot, so no extra block
  function automatic logic turn_block(input ssm_cmd_t c);
    turn_block = 1'b0 & (c == SSM_CMD_DUMMY_READ);
  endfunction : turn_block

  assign link.cmd           = cmd_reg;
  assign link.addr          = addr_reg;
  assign link.ctl_dq_o      = wdata_reg;
  assign link.ctl_dq_oe     = dq_oe_reg;
  assign link.sleep_request = sleep_reg;
endmodule : ssm_ctl

// [dv/ssm_properties.sv]
// link checker: controller and memory end relations
// assumes one clock and the plain link signals
module ssm_properties
  import ssm_pkg::*;
(
  input wire logic     clk_i,
  input wire logic     rst_i,
  input wire ssm_cmd_t cmd,
  input wire logic     ctl_dq_oe,
  input wire logic     mem_dq_oe,
  input wire logic     sleep_request
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_wake; $fell(sleep_request); endsequence
  sequence s_no_wr; (cmd != SSM_CMD_WRITE) [*7]; endsequence
  a_idle_in_sleep: assert property (sleep_request |-> cmd == SSM_CMD_DESELECT)
    else $error("command while sleep requested");
  a_recov_no_write: assert property (s_wake |-> s_no_wr)
    else $error("write during recovery");
  a_dq_off_asleep: assert property (sleep_request [*2] |-> !mem_dq_oe)
    else $error("memory drives bus in sleep");
  a_ctl_quiet_sleep: assert property (sleep_request |-> !ctl_dq_oe)
    else $error("controller drives bus in sleep");
  a_dq_after_read: assert property (mem_dq_oe |-> $past(cmd) == SSM_CMD_READ)
    else $error("memory drive without read");
  a_dummy_no_drive: assert property (cmd == SSM_CMD_DUMMY_READ |=> !mem_dq_oe)
    else $error("dummy read drove bus");
  a_bus_no_clash: assert property (!(ctl_dq_oe && mem_dq_oe))
    else $error("bus contention");
  a_rd_wr_turn: assert property (cmd == SSM_CMD_READ |=> cmd != SSM_CMD_WRITE)
    else $error("write right after read");
endmodule : ssm_properties

// [dv/sram_sleep_mode_control_test.sv]
// bench for both link ends; reads queue expected data
// assumes package constants and a 4 ns clock
module sram_sleep_mode_control_test
  import ssm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rst_i = 1, req_valid = 0, req_write = 0, sleep_i = 0;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [DATA_W-1:0] req_wdata = '0, rd_data, ref_mem [DEPTH], exp_q [$];
  logic req_ready, rd_valid, asleep, recovering, wviol, sleeping;
  int n_errors = 0, num_checks = 0, cyc = 0, n;
  ssm_if link ();
  ssm_ctl u_ssm_ctl (.clk_i, .rst_i, .link(link.ctl), .req_valid_i(req_valid), .req_write_i(req_write),
    .req_addr_i(req_addr), .req_wdata_i(req_wdata), .sleep_i(sleep_i), .req_ready_o(req_ready),
    .rd_valid_o(rd_valid), .rd_data_o(rd_data), .sleeping_o(sleeping));
  ssm_mem u_ssm_mem (.clk_i, .rst_i, .link(link.mem), .asleep_o(asleep), .recovering_o(recovering),
    .write_violation_o(wviol));
  ssm_properties u_ssm_properties (.clk_i, .rst_i, .cmd(link.cmd), .ctl_dq_oe(link.ctl_dq_oe),
    .mem_dq_oe(link.mem_dq_oe), .sleep_request(link.sleep_request));
  initial forever #2 clk_i = ~clk_i;
  task automatic chk(input string nm, input logic [DATA_W-1:0] s, e);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  // request held until taken; a dropped write leaves the model alone
  task automatic req(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input bit drop = 0);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    do @(posedge clk_i); while (req_ready !== 1'b1);
    if (!w) exp_q.push_back(ref_mem[a]);
    else if (!drop) ref_mem[a] = d;
  endtask : req
  task automatic idle(input int k);
    req_valid <= 1'b0;
    repeat (k) @(posedge clk_i);
  endtask : idle
  always @(posedge clk_i) begin
    cyc++;
    if (rd_valid === 1'b1) chk("rd_data", rd_data, exp_q.size() ? exp_q.pop_front() : 'x);
    if (wviol === 1'b1) chk("violation", wviol, 1'b0);
    if (cyc == 4000) begin
      n_errors++;
      stop_test();
    end
  end
  initial begin
    logic [ADDR_W-1:0] a [8];
    void'($urandom(7));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("sleep_req", link.sleep_request, 1'b0);
    for (int i = 0; i < 8; i++) begin
      a[i] = ADDR_W'(i * 32 + $urandom_range(0, 31));
      req(1'b1, a[i], DATA_W'($urandom));
    end
    for (int i = 0; i < 8; i++) req(1'b0, a[i], '0);
    idle(4);
    $display("test basic done");
    req(1'b0, a[0], '0);
    req(1'b1, a[0], ~ref_mem[a[0]], 1'b1);
    idle(2);
    req(1'b0, a[0], '0);
    idle(6);
    $display("test turn done");
    // sleep first, so the held write is refused until recovery ends and only then taken
    sleep_i <= 1'b1;
    @(posedge clk_i);
    req_valid <= 1'b1;
    req_write <= 1'b1;
    req_addr <= a[1];
    req_wdata <= DATA_W'($urandom);
    do @(posedge clk_i); while (link.sleep_request !== 1'b1);
    n = 0;
    do begin @(posedge clk_i); n++; end while (asleep !== 1'b1);
    chk("entry", n, SLEEP_ENTRY_CYC + 3);
    repeat (20) @(posedge clk_i);
    chk("asleep", asleep, 1'b1);
    chk("ready", req_ready, 1'b0);
    chk("sleeping", sleeping, 1'b1);
    sleep_i <= 1'b0;
    do @(posedge clk_i); while (recovering !== 1'b1);
    n = 0;
    do begin @(posedge clk_i); n++; end while (recovering === 1'b1);
    chk("recovery", n, SLEEP_RECOVERY_CYC);
    chk("awake", asleep, 1'b0);
    chk("sleeping", sleeping, 1'b0);
    // the held write is taken three times, from the first edge where ready is back after recovery to the edge this wait ends on; valid drops right after
    do @(posedge clk_i); while (req_ready !== 1'b1);
    ref_mem[a[1]] = req_wdata;
    idle(2);
    for (int i = 0; i < 8; i++) req(1'b0, a[i], '0);
    idle(6);
    $display("test sleep done");
    stop_test();
  end
endmodule : sram_sleep_mode_control_test
